/* inc/pmic_int_pkg.sv */
// Constants for the hierarchical interrupt status block.
// Summary of operation
// [R1] Top bit7 follows state-machine error detail nonzero.
// [R2] Top bit6 follows severe error detail nonzero.
// [R3] Top bit5 follows moderate error detail nonzero.
// [R4] Top bit4 follows miscellaneous event detail nonzero.
// [R5] Top bit3 follows start-up event detail nonzero.
// [R6] Top bit2 follows pin event detail nonzero.
// [R7] Top bit1 follows voltage monitor detail nonzero.
// [R8] Top bit0 follows converter summary; read-only, resets zero.
// [R9] Converter summary bit1 follows phase34 flags nonzero.
// [R10] Converter summary bit0 follows phase12; rest reserved.
// [R11] Phase2 current limit latches, write one clears.
// [R12] Phase2 short circuit latches, write one clears.
// [R13] Phase2 under-voltage latches, write one clears.
// [R14] Phase2 over-voltage latches, write one clears.
// [R15] Phase1 current limit latches, write one clears.
// [R16] Phase1 short circuit latches, write one clears.
// [R17] Phase1 under-voltage latches, write one clears.
// [R18] Phase1 over-voltage latches; flags reset zero.
// [R19] Phase34 register uses same latched layout.
// [R20] Zero writes and summary writes change nothing.
// [R21] Host descends summaries and clears set flags.
package pmic_int_pkg;
  localparam logic [7:0] TOP_SUMMARY_ADDR   = 8'h5a;
  localparam logic [7:0] CONV_SUMMARY_ADDR  = 8'h5b;
  localparam logic [7:0] PHASE12_FLAGS_ADDR = 8'h5c;
  localparam logic [7:0] PHASE34_FLAGS_ADDR = 8'h5d;
  localparam logic [7:0] FLAGS_RESET        = 8'h00;
  localparam int         ILIM_BIT           = 3;
  localparam int         SHORT_BIT          = 2;
  localparam int         UV_BIT             = 1;
  localparam int         OV_BIT             = 0;
endpackage

/* design/pmic_interrupt_hierarchy.sv */
// Hierarchical interrupt status registers with write-one-to-clear converter fault flags.
`timescale 1ns/1ps
module pmic_interrupt_hierarchy (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  input  wire logic [3:0] i_phase_current_limit,
  input  wire logic [3:0] i_phase_short_below_run,
  input  wire logic [3:0] i_phase_short_no_rise,
  input  wire logic [3:0] i_phase_short_high_early,
  input  wire logic [3:0] i_phase_undervoltage,
  input  wire logic [3:0] i_phase_overvoltage,
  input  wire logic [7:0] i_state_machine_error_detail,
  input  wire logic [7:0] i_severe_error_detail,
  input  wire logic [7:0] i_moderate_error_detail,
  input  wire logic [7:0] i_misc_event_detail,
  input  wire logic [7:0] i_powerup_event_detail,
  input  wire logic [7:0] i_gpio_event_detail,
  input  wire logic [7:0] i_voltage_monitor_detail,
  output logic      [7:0] o_top_event_summary,
  output logic      [7:0] o_converter_group_summary
);
  import pmic_int_pkg::*;

  logic [7:0] phase12_events;
  logic [7:0] phase34_events;
  logic [7:0] phase12_clear;
  logic [7:0] phase34_clear;
  logic [7:0] phase12_fault_flags;
  logic [7:0] phase34_fault_flags;
  logic [7:0] phase12_fault_flags_nxt;
  logic [7:0] phase34_fault_flags_nxt;
  logic [7:0] conv_summary_nxt;
  logic [7:0] top_summary_nxt;
  logic       phase12_write;
  logic       phase34_write;

  // Builds the four fault events of one converter phase in register order.
  function automatic logic [3:0] phase_events(input logic [3:0] idx);
    logic [3:0] ev;
    ev = 4'h0;
    ev[ILIM_BIT]  = i_phase_current_limit[idx[1:0]];
    ev[SHORT_BIT] = i_phase_short_below_run[idx[1:0]] | i_phase_short_no_rise[idx[1:0]]
                  | i_phase_short_high_early[idx[1:0]];
    ev[UV_BIT]    = i_phase_undervoltage[idx[1:0]];
    ev[OV_BIT]    = i_phase_overvoltage[idx[1:0]];
    return ev;
  endfunction

  // Next value of one latched flag; a new event wins over a clear in the same cycle.
  function automatic logic w1c_next(input logic held, input logic event_in, input logic clear);
    return event_in | (held & ~clear);
  endfunction

  // Second phase of each pair sits in the upper nibble.
  assign phase12_events = {phase_events(4'h1), phase_events(4'h0)}; // [R12] [R16]
  assign phase34_events = {phase_events(4'h3), phase_events(4'h2)}; // [R19]

  // Only bits written as one clear; summary addresses never reach a flag.
  assign phase12_write = i_reg_wr && (i_reg_addr == PHASE12_FLAGS_ADDR); // [R20]
  assign phase34_write = i_reg_wr && (i_reg_addr == PHASE34_FLAGS_ADDR); // [R20]
  assign phase12_clear = phase12_write ? i_reg_wdata : 8'h00; // [R20]
  assign phase34_clear = phase34_write ? i_reg_wdata : 8'h00; // [R20]

  // Latched fault flags of the second phase, one process each.
  logic phase2_current_limit_flag_r;
  logic phase2_current_limit_flag_nxt;
  assign phase2_current_limit_flag_nxt = w1c_next(phase2_current_limit_flag_r,
                                                  phase12_events[7], phase12_clear[7]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase2_current_limit_flag_r <= FLAGS_RESET[7];
    end else begin
      phase2_current_limit_flag_r <= phase2_current_limit_flag_nxt; // [R11]
    end
  end

  logic phase2_short_flag_r;
  logic phase2_short_flag_nxt;
  assign phase2_short_flag_nxt = w1c_next(phase2_short_flag_r,
                                          phase12_events[6], phase12_clear[6]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase2_short_flag_r <= FLAGS_RESET[6];
    end else begin
      phase2_short_flag_r <= phase2_short_flag_nxt; // [R12]
    end
  end

  logic phase2_undervoltage_flag_r;
  logic phase2_undervoltage_flag_nxt;
  assign phase2_undervoltage_flag_nxt = w1c_next(phase2_undervoltage_flag_r,
                                                 phase12_events[5], phase12_clear[5]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase2_undervoltage_flag_r <= FLAGS_RESET[5];
    end else begin
      phase2_undervoltage_flag_r <= phase2_undervoltage_flag_nxt; // [R13]
    end
  end

  logic phase2_overvoltage_flag_r;
  logic phase2_overvoltage_flag_nxt;
  assign phase2_overvoltage_flag_nxt = w1c_next(phase2_overvoltage_flag_r,
                                                phase12_events[4], phase12_clear[4]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase2_overvoltage_flag_r <= FLAGS_RESET[4];
    end else begin
      phase2_overvoltage_flag_r <= phase2_overvoltage_flag_nxt; // [R14]
    end
  end

  // Latched fault flags of the first phase, one process each.
  logic phase1_current_limit_flag_r;
  logic phase1_current_limit_flag_nxt;
  assign phase1_current_limit_flag_nxt = w1c_next(phase1_current_limit_flag_r,
                                                  phase12_events[3], phase12_clear[3]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase1_current_limit_flag_r <= FLAGS_RESET[3];
    end else begin
      phase1_current_limit_flag_r <= phase1_current_limit_flag_nxt; // [R15]
    end
  end

  logic phase1_short_flag_r;
  logic phase1_short_flag_nxt;
  assign phase1_short_flag_nxt = w1c_next(phase1_short_flag_r,
                                          phase12_events[2], phase12_clear[2]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase1_short_flag_r <= FLAGS_RESET[2];
    end else begin
      phase1_short_flag_r <= phase1_short_flag_nxt; // [R16]
    end
  end

  logic phase1_undervoltage_flag_r;
  logic phase1_undervoltage_flag_nxt;
  assign phase1_undervoltage_flag_nxt = w1c_next(phase1_undervoltage_flag_r,
                                                 phase12_events[1], phase12_clear[1]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase1_undervoltage_flag_r <= FLAGS_RESET[1];
    end else begin
      phase1_undervoltage_flag_r <= phase1_undervoltage_flag_nxt; // [R17]
    end
  end

  logic phase1_overvoltage_flag_r;
  logic phase1_overvoltage_flag_nxt;
  assign phase1_overvoltage_flag_nxt = w1c_next(phase1_overvoltage_flag_r,
                                                phase12_events[0], phase12_clear[0]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase1_overvoltage_flag_r <= FLAGS_RESET[0]; // [R18]
    end else begin
      phase1_overvoltage_flag_r <= phase1_overvoltage_flag_nxt; // [R18]
    end
  end

  // Latched fault flags of the fourth phase, one process each.
  logic phase4_current_limit_flag_r;
  logic phase4_current_limit_flag_nxt;
  assign phase4_current_limit_flag_nxt = w1c_next(phase4_current_limit_flag_r,
                                                  phase34_events[7], phase34_clear[7]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase4_current_limit_flag_r <= FLAGS_RESET[7];
    end else begin
      phase4_current_limit_flag_r <= phase4_current_limit_flag_nxt; // [R19]
    end
  end

  logic phase4_short_flag_r;
  logic phase4_short_flag_nxt;
  assign phase4_short_flag_nxt = w1c_next(phase4_short_flag_r,
                                          phase34_events[6], phase34_clear[6]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase4_short_flag_r <= FLAGS_RESET[6];
    end else begin
      phase4_short_flag_r <= phase4_short_flag_nxt; // [R19]
    end
  end

  logic phase4_undervoltage_flag_r;
  logic phase4_undervoltage_flag_nxt;
  assign phase4_undervoltage_flag_nxt = w1c_next(phase4_undervoltage_flag_r,
                                                 phase34_events[5], phase34_clear[5]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase4_undervoltage_flag_r <= FLAGS_RESET[5];
    end else begin
      phase4_undervoltage_flag_r <= phase4_undervoltage_flag_nxt; // [R19]
    end
  end

  logic phase4_overvoltage_flag_r;
  logic phase4_overvoltage_flag_nxt;
  assign phase4_overvoltage_flag_nxt = w1c_next(phase4_overvoltage_flag_r,
                                                phase34_events[4], phase34_clear[4]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase4_overvoltage_flag_r <= FLAGS_RESET[4];
    end else begin
      phase4_overvoltage_flag_r <= phase4_overvoltage_flag_nxt; // [R19]
    end
  end

  // Latched fault flags of the third phase, one process each.
  logic phase3_current_limit_flag_r;
  logic phase3_current_limit_flag_nxt;
  assign phase3_current_limit_flag_nxt = w1c_next(phase3_current_limit_flag_r,
                                                  phase34_events[3], phase34_clear[3]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase3_current_limit_flag_r <= FLAGS_RESET[3];
    end else begin
      phase3_current_limit_flag_r <= phase3_current_limit_flag_nxt; // [R19]
    end
  end

  logic phase3_short_flag_r;
  logic phase3_short_flag_nxt;
  assign phase3_short_flag_nxt = w1c_next(phase3_short_flag_r,
                                          phase34_events[2], phase34_clear[2]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase3_short_flag_r <= FLAGS_RESET[2];
    end else begin
      phase3_short_flag_r <= phase3_short_flag_nxt; // [R19]
    end
  end

  logic phase3_undervoltage_flag_r;
  logic phase3_undervoltage_flag_nxt;
  assign phase3_undervoltage_flag_nxt = w1c_next(phase3_undervoltage_flag_r,
                                                 phase34_events[1], phase34_clear[1]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase3_undervoltage_flag_r <= FLAGS_RESET[1];
    end else begin
      phase3_undervoltage_flag_r <= phase3_undervoltage_flag_nxt; // [R19]
    end
  end

  logic phase3_overvoltage_flag_r;
  logic phase3_overvoltage_flag_nxt;
  assign phase3_overvoltage_flag_nxt = w1c_next(phase3_overvoltage_flag_r,
                                                phase34_events[0], phase34_clear[0]);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase3_overvoltage_flag_r <= FLAGS_RESET[0];
    end else begin
      phase3_overvoltage_flag_r <= phase3_overvoltage_flag_nxt; // [R19]
    end
  end

  // Register images of the two fault groups, second phase of a pair in the upper nibble.
  assign phase12_fault_flags = {
    phase2_current_limit_flag_r, phase2_short_flag_r,
    phase2_undervoltage_flag_r, phase2_overvoltage_flag_r,
    phase1_current_limit_flag_r, phase1_short_flag_r,
    phase1_undervoltage_flag_r, phase1_overvoltage_flag_r
  };

  assign phase34_fault_flags = {
    phase4_current_limit_flag_r, phase4_short_flag_r,
    phase4_undervoltage_flag_r, phase4_overvoltage_flag_r,
    phase3_current_limit_flag_r, phase3_short_flag_r,
    phase3_undervoltage_flag_r, phase3_overvoltage_flag_r
  };

  // Next-state images feed the summaries so that they track the flags in the same cycle.
  assign phase12_fault_flags_nxt = {
    phase2_current_limit_flag_nxt, phase2_short_flag_nxt,
    phase2_undervoltage_flag_nxt, phase2_overvoltage_flag_nxt,
    phase1_current_limit_flag_nxt, phase1_short_flag_nxt,
    phase1_undervoltage_flag_nxt, phase1_overvoltage_flag_nxt
  };

  assign phase34_fault_flags_nxt = {
    phase4_current_limit_flag_nxt, phase4_short_flag_nxt,
    phase4_undervoltage_flag_nxt, phase4_overvoltage_flag_nxt,
    phase3_current_limit_flag_nxt, phase3_short_flag_nxt,
    phase3_undervoltage_flag_nxt, phase3_overvoltage_flag_nxt
  };

  assign conv_summary_nxt = {
    6'h00,                    // [R10]
    |phase34_fault_flags_nxt, // [R9]
    |phase12_fault_flags_nxt  // [R10]
  };

  assign top_summary_nxt = {
    |i_state_machine_error_detail, // [R1]
    |i_severe_error_detail,        // [R2]
    |i_moderate_error_detail,      // [R3]
    |i_misc_event_detail,          // [R4]
    |i_powerup_event_detail,       // [R5]
    |i_gpio_event_detail,          // [R6]
    |i_voltage_monitor_detail,     // [R7]
    |conv_summary_nxt              // [R8]
  };

  // Converter summary register.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_converter_group_summary <= FLAGS_RESET;
    end else begin
      o_converter_group_summary <= conv_summary_nxt; // [R9] [R10]
    end
  end

  // Top summary register.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_top_event_summary <= FLAGS_RESET; // [R8]
    end else begin
      o_top_event_summary <= top_summary_nxt;
    end
  end

  // Read data returns one cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          TOP_SUMMARY_ADDR:   o_reg_rdata <= o_top_event_summary;
          CONV_SUMMARY_ADDR:  o_reg_rdata <= o_converter_group_summary;
          PHASE12_FLAGS_ADDR: o_reg_rdata <= phase12_fault_flags;
          PHASE34_FLAGS_ADDR: o_reg_rdata <= phase34_fault_flags;
          default:            o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

/* sim/pmic_int_properties.sv */
// Checker for the interrupt status block.
`timescale 1ns/1ps
module pmic_int_properties (input wire logic i_core_clk, i_reset, i_reg_wr, i_reg_rd, o_reg_rvalid,
  input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_top_event_summary,
  input wire logic [7:0] o_converter_group_summary, i_state_machine_error_detail,
  input wire logic [3:0] i_phase_current_limit);
  import pmic_int_pkg::*;
  wire [7:0] t = o_top_event_summary;
  wire [7:0] c = o_converter_group_summary;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  property p_top7; !$past(i_reset) |-> t[7] == |$past(i_state_machine_error_detail); endproperty
  a_top7: assert property (p_top7) else $error("top bit 7 wrong");
  property p_top0; t[0] == |c; endproperty
  a_top0: assert property (p_top0) else $error("top bit 0 wrong");
  property p_rsv; c[7:2] == 6'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_set12; !$past(i_reset) && |$past(i_phase_current_limit[1:0]) |-> c[0]; endproperty
  a_set12: assert property (p_set12) else $error("phase12 not latched");
  property p_set34; !$past(i_reset) && |$past(i_phase_current_limit[3:2]) |-> c[1]; endproperty
  a_set34: assert property (p_set34) else $error("phase34 not latched");
  property p_hold;
    c[0] && !(i_reg_wr && i_reg_addr == PHASE12_FLAGS_ADDR && i_reg_wdata != 8'h00) |=> c[0];
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_rtop; i_reg_rd && i_reg_addr == TOP_SUMMARY_ADDR |=> o_reg_rdata == $past(t); endproperty
  a_rtop: assert property (p_rtop) else $error("top read wrong");
  property p_rcnv; i_reg_rd && i_reg_addr == CONV_SUMMARY_ADDR |=> o_reg_rdata == $past(c); endproperty
  a_rcnv: assert property (p_rcnv) else $error("summary read wrong");
  c_clr: cover property (c[1] ##1 !c[1]);
  c_top7: cover property (t[7]);
  c_w1c: cover property (i_reg_wr && i_reg_addr == PHASE34_FLAGS_ADDR);
endmodule
bind pmic_interrupt_hierarchy pmic_int_properties chk_i (.*);

/* sim/host_model.sv */
// Host model issuing register reads and writes.
`timescale 1ns/1ps
module host_model (input wire logic i_core_clk, output logic o_wr, o_rd,
  output logic [7:0] o_addr, o_wdata);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
  task automatic op(input logic w, input logic [7:0] a, d);
    @(posedge i_core_clk) #1 {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
    @(posedge i_core_clk) #1 {o_wr, o_rd, o_addr} = {2'h0, ~a};
  endtask
endmodule

/* sim/pmic_interrupt_hierarchy_bench.sv */
// Self-checking bench for the interrupt status block.
`timescale 1ns/1ps
module pmic_interrupt_hierarchy_bench;
  import pmic_int_pkg::*;
  logic i_core_clk = 0, i_reset = 1, wr, rd, rv;
  logic [7:0] addr, wd, rdata, top, conv, e, b, ra, dt[7], q[$];
  logic [3:0] ev[6];
  int miscompares = 0, checks = 0, cyc = 0;
  always #50 i_core_clk = ~i_core_clk;
  host_model host_model_i (.i_core_clk, .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wd));
  pmic_interrupt_hierarchy pmic_interrupt_hierarchy_i (.i_core_clk, .i_reset, .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_rvalid(rv),
    .i_phase_current_limit(ev[0]), .i_phase_short_below_run(ev[1]), .i_phase_short_no_rise(ev[2]),
    .i_phase_short_high_early(ev[3]), .i_phase_undervoltage(ev[4]), .i_phase_overvoltage(ev[5]),
    .i_state_machine_error_detail(dt[6]), .i_severe_error_detail(dt[5]),
    .i_moderate_error_detail(dt[4]), .i_misc_event_detail(dt[3]), .i_powerup_event_detail(dt[2]),
    .i_gpio_event_detail(dt[1]), .i_voltage_monitor_detail(dt[0]), .o_top_event_summary(top),
    .o_converter_group_summary(conv));
  task automatic rd_exp(input logic [7:0] a, x);
    q.push_back(x);
    host_model_i.op(1'b0, a, 8'h00);
  endtask
  task automatic cmp(input logic [7:0] got, x);
    checks++;
    if (got !== x) begin
      miscompares++;
      $display("wrong value at %0t: read %h expected %h", $time, got, x);
    end
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(negedge i_core_clk) if (rv === 1'b1) cmp(rdata, q.pop_front());
  always @(posedge i_core_clk) if (++cyc > 20000) begin
    miscompares++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'ha429));
    ev = '{default: 4'h0};
    dt = '{default: 8'h00};
    repeat (8) @(posedge i_core_clk);
    #1 i_reset = 0;
    for (int a = 'h5a; a < 'h5f; a++) rd_exp(8'(a), 8'h00);
    for (int p = 0; p < 4; p++) for (int k = 0; k < 6; k++) begin
      b = 8'h01 << ((p[0] ? 4 : 0) + (k == 0 ? 3 : k < 4 ? 2 : 5 - k));
      ra = p < 2 ? PHASE12_FLAGS_ADDR : PHASE34_FLAGS_ADDR;
      @(posedge i_core_clk) #1 ev[k][p] = 1'b1;
      @(posedge i_core_clk) #1 ev[k][p] = 1'b0;
      host_model_i.op(1'b1, ra, ~b);
      host_model_i.op(1'b1, TOP_SUMMARY_ADDR, 8'hff);
      rd_exp(ra, b);
      rd_exp(CONV_SUMMARY_ADDR, p < 2 ? 8'h01 : 8'h02);
      rd_exp(TOP_SUMMARY_ADDR, 8'h01);
      host_model_i.op(1'b1, ra, b);
      rd_exp(ra, 8'h00);
      rd_exp(TOP_SUMMARY_ADDR, 8'h00);
    end
    repeat (8) begin
      @(posedge i_core_clk) #1 e = 8'h00;
      foreach (dt[i]) dt[i] = $urandom_range(0, 1) ? 8'($urandom) : 8'h00;
      foreach (dt[i]) e[i + 1] = |dt[i];
      rd_exp(TOP_SUMMARY_ADDR, e);
    end
    repeat (4) @(posedge i_core_clk);
    report_and_stop;
  end
endmodule
